// ---- power_down_pkg.sv ----
package power_down_pkg;

  localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STOP_A = 4'h4;
  localparam logic [3:0] ADDR_STOP_B = 4'h8;
  localparam logic [3:0] ADDR_STOP_C = 4'hC;

  // writable bit masks; everything else reads as zero
  localparam logic [7:0] MASK_STANDBY_CONTROL = 8'h88;
  localparam logic [7:0] MASK_STOP_A = 8'hC6;
  localparam logic [7:0] MASK_STOP_B = 8'h17;
  localparam logic [7:0] MASK_STOP_C = 8'h11;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  localparam int BIT_STANDBY_SELECT = 7;
  localparam int BIT_MODE_PIN_REFLECT = 3;
  localparam int BIT_STOP_DEBUG_IF = 7;
  localparam int BIT_STOP_BREAK_CTL = 6;
  localparam int BIT_STOP_CACHE = 2;
  localparam int BIT_STOP_USER_MEMORY = 1;
  localparam int BIT_STOP_MATCH_TIMER = 4;
  localparam int BIT_STOP_SERIAL_2 = 2;
  localparam int BIT_STOP_SERIAL_1 = 1;
  localparam int BIT_STOP_SERIAL_0 = 0;
  localparam int BIT_STOP_HOST_IF = 4;
  localparam int BIT_STOP_ETHERNET = 0;

  localparam logic [7:0] WATCHDOG_START = 8'h00;
  localparam logic [7:0] WATCHDOG_RELOCK = 8'h80;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;

  // clock gate enables, one per gated module
  typedef struct packed {
    logic debug_interface;
    logic break_controller;
    logic cache;
    logic user_memory;
    logic match_timer;
    logic serial_channel_2;
    logic serial_channel_1;
    logic serial_channel_0;
    logic host_interface;
    logic ethernet;
  } module_clk_en_s;

  // interrupt requests as seen by the power-down logic
  typedef struct packed {
    logic nmi;
    logic debug_irq;
    logic user_break;
    logic ext_irq;
    logic [3:0] ext_irq_priority;
    logic [1:0] ext_irq_sense;
    logic ext_irq_match;
    logic periph_irq;
    logic [3:0] periph_irq_priority;
  } wake_req_s;

  typedef enum {
    RUN, LIGHT_SLEEP, DEEP_STANDBY, SETTLING, LOCKED_STANDBY
  } power_state_e;

endpackage

// ---- power_down_mode_controller.sv ----
// Operation
// - halt with select 0 enters light sleep; peripherals, clock out run
// - halt with standby select 1 enters deep standby; all clocks stop
// - light sleep ends on any accepted interrupt except user break
// - in light sleep, external or peripheral interrupt not above mask level is refused
// - light sleep also ends on power-on reset or debug reset
// - core and cache registers are kept on deep standby entry
// - match timer registers are initialised in deep standby; others kept
// - nmi or external wake starts watchdog; clocks return after settling
// - clearing standby select after wake stops the watchdog counter
// - select still set: at count 80h re-enter standby until reset
// - external line wakes deep standby only with sense not 00 and match
// - external wake at or below mask resumes after halt, else exception
// - power-on reset ends deep standby; clock output driven during reset
// - reflect bit set applies mode pins on interrupt wake from standby
// - module stop bit 1 stops that peripheral clock
// - clearing module stop bit or power-on reset releases the gate
// - stop reg a: bits 7,6,2,1 gate debug, break, cache, user memory
// - stop register b: bit 4 match timer, bits 2,1,0 serial 2,1,0
// - stop register c: bit 4 host interface, bit 0 ethernet and its dma
// - reserved bits of the four registers read as zero
// - watchdog overflow on standby exit does not set the overflow flag
`timescale 1ns/10ps
`default_nettype none

module power_down_mode_controller #(
  parameter int COUNT_WIDTH = 8,
  parameter int PRESCALE_WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_exec,
  input wire logic debug_reset,
  input wire logic [3:0] core_mask_level,
  input wire power_down_pkg::wake_req_s wake_req,
  input wire logic [2:0] watchdog_clock_divider,
  input wire logic [2:0] mode_pins,
  output logic core_halt,
  output logic internal_clk_en,
  output logic periph_clk_en,
  output logic external_clock_output_en,
  output logic match_timer_init,
  output logic take_exception,
  output logic resume_after_halt,
  output logic mode_apply,
  output logic [2:0] mode_applied,
  output logic watchdog_overflow_flag_set,
  output logic [COUNT_WIDTH-1:0] watchdog_counter,
  output power_down_pkg::module_clk_en_s module_clk_en
);

  power_down_pkg::power_state_e state, next_state;
  logic [7:0] standby_control;
  logic [7:0] module_clock_stop_a;
  logic [7:0] module_clock_stop_b;
  logic [7:0] module_clock_stop_c;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic counting;

  function automatic logic [3:0] div_shift(input logic [2:0] sel);
    case (sel)
      3'h0: div_shift = 4'h0;
      3'h1: div_shift = 4'h2;
      3'h2: div_shift = 4'h4;
      3'h3: div_shift = 4'h5;
      3'h4: div_shift = 4'h6;
      3'h5: div_shift = 4'h8;
      3'h6: div_shift = 4'hA;
      default: div_shift = 4'hC;
    endcase
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // register decode
  wire sel_ctl = hit(reg_addr, power_down_pkg::ADDR_STANDBY_CONTROL);
  wire sel_a = hit(reg_addr, power_down_pkg::ADDR_STOP_A);
  wire sel_b = hit(reg_addr, power_down_pkg::ADDR_STOP_B);
  wire sel_c = hit(reg_addr, power_down_pkg::ADDR_STOP_C);
  wire [7:0] rd_mux = sel_ctl ? standby_control :
                      sel_a ? module_clock_stop_a :
                      sel_b ? module_clock_stop_b :
                      sel_c ? module_clock_stop_c : 8'h00;
  wire [7:0] rd_mask = sel_ctl ? power_down_pkg::MASK_STANDBY_CONTROL :
                       sel_a ? power_down_pkg::MASK_STOP_A :
                       sel_b ? power_down_pkg::MASK_STOP_B :
                       sel_c ? power_down_pkg::MASK_STOP_C : 8'h00;
  wire standby_select =
    standby_control[power_down_pkg::BIT_STANDBY_SELECT];
  wire mode_pin_reflect =
    standby_control[power_down_pkg::BIT_MODE_PIN_REFLECT];

  // interrupt acceptance; user break never wakes
  wire ext_ok = wake_req.ext_irq &&
                (wake_req.ext_irq_priority > core_mask_level);
  wire periph_ok = wake_req.periph_irq &&
                   (wake_req.periph_irq_priority > core_mask_level);
  wire sleep_wake = wake_req.nmi || wake_req.debug_irq ||
                    ext_ok || periph_ok;
  wire ext_standby_wake = wake_req.ext_irq && wake_req.ext_irq_match &&
    (wake_req.ext_irq_sense != power_down_pkg::SENSE_LOW_LEVEL);
  wire standby_wake = wake_req.nmi || ext_standby_wake;

  // watchdog tick from the selected divider
  wire [PRESCALE_WIDTH:0] prescale_span =
    (PRESCALE_WIDTH+1)'(1) << div_shift(watchdog_clock_divider);
  wire [PRESCALE_WIDTH-1:0] prescale_top =
    PRESCALE_WIDTH'(prescale_span - (PRESCALE_WIDTH+1)'(1));
  wire tick = (prescale == prescale_top);
  wire settle_done = (state == power_down_pkg::SETTLING) && tick &&
                     (watchdog_counter == {COUNT_WIDTH{1'b1}});
  wire relock = counting && tick &&
    (watchdog_counter == COUNT_WIDTH'(power_down_pkg::WATCHDOG_RELOCK)
                         - COUNT_WIDTH'(1));

  always_comb begin
    next_state = state;
    case (state)
      power_down_pkg::RUN: begin
        if (relock) begin
          next_state = power_down_pkg::LOCKED_STANDBY;
        end else if (halt_exec && standby_select) begin
          next_state = power_down_pkg::DEEP_STANDBY;
        end else if (halt_exec) begin
          next_state = power_down_pkg::LIGHT_SLEEP;
        end
      end
      power_down_pkg::LIGHT_SLEEP: begin
        if (sleep_wake || debug_reset) begin
          next_state = power_down_pkg::RUN;
        end
      end
      power_down_pkg::DEEP_STANDBY: begin
        if (standby_wake) begin
          next_state = power_down_pkg::SETTLING;
        end
      end
      power_down_pkg::SETTLING: begin
        if (settle_done) begin
          next_state = power_down_pkg::RUN;
        end
      end
      power_down_pkg::LOCKED_STANDBY: next_state = state;
      default: next_state = power_down_pkg::RUN;
    endcase
  end

  wire next_asleep = (next_state != power_down_pkg::RUN);
  wire next_deep = (next_state == power_down_pkg::DEEP_STANDBY) ||
                   (next_state == power_down_pkg::SETTLING) ||
                   (next_state == power_down_pkg::LOCKED_STANDBY);
  // clocks stay off through settling until the count completes
  wire next_stopped = (next_state == power_down_pkg::DEEP_STANDBY) ||
                      (next_state == power_down_pkg::SETTLING) ||
                      (next_state == power_down_pkg::LOCKED_STANDBY);
  wire sleep_exit = (state == power_down_pkg::LIGHT_SLEEP) &&
                    (next_state == power_down_pkg::RUN);
  wire next_exception = (sleep_exit && sleep_wake && !debug_reset) ||
    (settle_done && (wake_req.nmi || ext_ok));
  wire next_resume = settle_done && !wake_req.nmi && !ext_ok;

  wire [7:0] next_stop_a = reg_wr && sel_a ?
    (reg_wdata & power_down_pkg::MASK_STOP_A) : module_clock_stop_a;
  wire [7:0] next_stop_b = reg_wr && sel_b ?
    (reg_wdata & power_down_pkg::MASK_STOP_B) : module_clock_stop_b;
  wire [7:0] next_stop_c = reg_wr && sel_c ?
    (reg_wdata & power_down_pkg::MASK_STOP_C) : module_clock_stop_c;

  // enables follow the stored next value so the gate sees a flop output
  power_down_pkg::module_clk_en_s next_clk_en;
  assign next_clk_en = '{
    debug_interface: !next_stop_a[power_down_pkg::BIT_STOP_DEBUG_IF],
    break_controller: !next_stop_a[power_down_pkg::BIT_STOP_BREAK_CTL],
    cache: !next_stop_a[power_down_pkg::BIT_STOP_CACHE],
    user_memory: !next_stop_a[power_down_pkg::BIT_STOP_USER_MEMORY],
    match_timer: !next_stop_b[power_down_pkg::BIT_STOP_MATCH_TIMER],
    serial_channel_2: !next_stop_b[power_down_pkg::BIT_STOP_SERIAL_2],
    serial_channel_1: !next_stop_b[power_down_pkg::BIT_STOP_SERIAL_1],
    serial_channel_0: !next_stop_b[power_down_pkg::BIT_STOP_SERIAL_0],
    host_interface: !next_stop_c[power_down_pkg::BIT_STOP_HOST_IF],
    ethernet: !next_stop_c[power_down_pkg::BIT_STOP_ETHERNET]
  };

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= power_down_pkg::RUN;
      standby_control <= power_down_pkg::RESET_VALUE;
      module_clock_stop_a <= power_down_pkg::RESET_VALUE;
      module_clock_stop_b <= power_down_pkg::RESET_VALUE;
      module_clock_stop_c <= power_down_pkg::RESET_VALUE;
      module_clk_en <= '1;
      reg_rdata <= 8'h00;
    end else begin
      state <= next_state;
      if (reg_wr && sel_ctl) begin
        standby_control <= reg_wdata & power_down_pkg::MASK_STANDBY_CONTROL;
      end
      module_clock_stop_a <= next_stop_a;
      module_clock_stop_b <= next_stop_b;
      module_clock_stop_c <= next_stop_c;
      module_clk_en <= next_clk_en;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // watchdog: settles in standby, then keeps counting while select stays set
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prescale <= '0;
      watchdog_counter <= '0;
      counting <= 1'b0;
    end else begin
      if (state == power_down_pkg::DEEP_STANDBY) begin
        prescale <= '0;
        watchdog_counter <= COUNT_WIDTH'(power_down_pkg::WATCHDOG_START);
      end else if (state == power_down_pkg::SETTLING || counting) begin
        prescale <= tick ? '0 : prescale + PRESCALE_WIDTH'(1);
        if (tick) begin
          watchdog_counter <= watchdog_counter + COUNT_WIDTH'(1);
        end
      end
      if (settle_done) begin
        counting <= 1'b1;
      end else if (!standby_select || relock) begin
        counting <= 1'b0;
      end
    end
  end

  // power outputs; reset value keeps the clock pin driven
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_halt <= 1'b0;
      internal_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      external_clock_output_en <= 1'b1;
      match_timer_init <= 1'b0;
      take_exception <= 1'b0;
      resume_after_halt <= 1'b0;
      mode_apply <= 1'b0;
      mode_applied <= 3'h0;
      watchdog_overflow_flag_set <= 1'b0;
    end else begin
      core_halt <= next_asleep;
      internal_clk_en <= !next_stopped;
      periph_clk_en <= !next_deep;
      external_clock_output_en <= !next_stopped;
      match_timer_init <= next_deep;
      take_exception <= next_exception;
      resume_after_halt <= next_resume;
      mode_apply <= settle_done && mode_pin_reflect;
      if (settle_done && mode_pin_reflect) begin
        mode_applied <= mode_pins;
      end
      // standby exit by overflow never raises the overflow flag
      watchdog_overflow_flag_set <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_sleep_entry: assert property (
    state == power_down_pkg::RUN && halt_exec && !standby_select && !relock
    |=> state == power_down_pkg::LIGHT_SLEEP ##0 periph_clk_en
        ##0 external_clock_output_en ##0 core_halt)
    else $error("light sleep entry wrong");
  a_deep_entry: assert property (
    state == power_down_pkg::RUN && halt_exec && standby_select && !relock
    |=> !internal_clk_en && !periph_clk_en && !external_clock_output_en)
    else $error("deep standby entry wrong");
  a_user_break_ignored: assert property (
    state == power_down_pkg::LIGHT_SLEEP && !sleep_wake && !debug_reset
    |=> state == power_down_pkg::LIGHT_SLEEP)
    else $error("sleep left without accepted cause");
  a_masked_ext_sleep: assert property (
    state == power_down_pkg::LIGHT_SLEEP && wake_req.ext_irq &&
    wake_req.ext_irq_priority <= core_mask_level && !wake_req.nmi &&
    !wake_req.debug_irq && !periph_ok && !debug_reset
    |=> state == power_down_pkg::LIGHT_SLEEP)
    else $error("masked interrupt woke sleep");
  a_sleep_exception: assert property (
    state == power_down_pkg::LIGHT_SLEEP && sleep_wake && !debug_reset
    |=> take_exception && !core_halt)
    else $error("no exception after sleep wake");
  a_debug_reset_exit: assert property (
    state == power_down_pkg::LIGHT_SLEEP && debug_reset
    |=> state == power_down_pkg::RUN)
    else $error("debug reset did not end sleep");
  a_match_timer_init: assert property (
    state == power_down_pkg::DEEP_STANDBY |-> match_timer_init)
    else $error("match timer not initialised in standby");
  a_low_level_no_wake: assert property (
    state == power_down_pkg::DEEP_STANDBY && !wake_req.nmi &&
    wake_req.ext_irq_sense == power_down_pkg::SENSE_LOW_LEVEL
    |=> state == power_down_pkg::DEEP_STANDBY)
    else $error("low level sense woke standby");
  a_settle_clocks_off: assert property (
    state == power_down_pkg::SETTLING
    |-> !internal_clk_en && !external_clock_output_en && !periph_clk_en)
    else $error("clocks before settling");
  a_counter_stops: assert property (
    state == power_down_pkg::RUN && !counting
    |=> $stable(watchdog_counter))
    else $error("counter runs with select clear");
  a_relock_hold: assert property (
    state == power_down_pkg::LOCKED_STANDBY
    |=> state == power_down_pkg::LOCKED_STANDBY ##0 !external_clock_output_en)
    else $error("locked standby left without reset");
  a_resume_path: assert property (
    settle_done |=> resume_after_halt != take_exception)
    else $error("wake exit both or neither");
  a_clock_during_reset: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> external_clock_output_en)
    else $error("clock output off after reset");
  a_mode_reflect: assert property (
    mode_apply |-> $past(mode_pin_reflect) && mode_applied == $past(mode_pins))
    else $error("mode pins applied wrongly");
  a_stop_gate: assert property (
    reg_wr && sel_b && reg_wdata[power_down_pkg::BIT_STOP_MATCH_TIMER]
    |=> !module_clk_en.match_timer)
    else $error("match timer clock not stopped");
  a_reserved_zero: assert property (
    reg_rd |=> (reg_rdata & ~$past(rd_mask)) == 8'h00)
    else $error("reserved bit read non zero");
  a_no_overflow_flag: assert property (
    settle_done |=> !watchdog_overflow_flag_set)
    else $error("overflow flag set on wake");

  c_sleep_wake: cover property (
    state == power_down_pkg::LIGHT_SLEEP ##1 take_exception);
  c_standby_wake: cover property (settle_done ##1 resume_after_halt);
  c_relock: cover property (state == power_down_pkg::LOCKED_STANDBY);
  c_gate_off: cover property (!module_clk_en.ethernet);

endmodule // power_down_mode_controller

`default_nettype wire

// ---- core_irq_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module core_irq_model (
  input wire logic core_clk,
  input wire logic take_exception,
  input wire logic resume_after_halt,
  output logic halt_exec,
  output logic debug_reset,
  output logic [3:0] core_mask_level,
  output power_down_pkg::wake_req_s wake_req,
  output logic [2:0] watchdog_clock_divider,
  output logic [2:0] mode_pins
);
  initial begin
    halt_exec = 1'b0;
    debug_reset = 1'b0;
    core_mask_level = 4'h0;
    wake_req = '0;
    // software picks the fastest divider before the first halt: 256-cycle settle
    watchdog_clock_divider = 3'h0;
    mode_pins = 3'h5;
  end

  // the interrupt controller withdraws a request once the core takes it
  always @(posedge core_clk) begin
    if (take_exception || resume_after_halt) begin
      wake_req <= '0;
    end
  end

  task automatic halt();
    @(posedge core_clk);
    halt_exec <= 1'b1;
    @(posedge core_clk);
    halt_exec <= 1'b0;
  endtask

  task automatic raise(input power_down_pkg::wake_req_s r);
    @(posedge core_clk);
    wake_req <= r;
  endtask

  task automatic set_div(input logic [2:0] v);
    @(posedge core_clk);
    watchdog_clock_divider <= v;
  endtask

  task automatic set_mask(input logic [3:0] m);
    @(posedge core_clk);
    core_mask_level <= m;
  endtask

  task automatic dbg_reset();
    @(posedge core_clk);
    debug_reset <= 1'b1;
    @(posedge core_clk);
    debug_reset <= 1'b0;
  endtask
endmodule // core_irq_model

`default_nettype wire

// ---- test_power_down_mode_controller.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_power_down_mode_controller;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, watchdog_counter, rv, d, c1;
  logic core_halt, internal_clk_en, periph_clk_en, ext_clk_en;
  logic match_timer_init, take_exception, resume_after_halt, mode_apply;
  logic watchdog_overflow_flag_set, halt_exec, debug_reset;
  logic [2:0] mode_applied, divider, mode_pins;
  logic [3:0] core_mask_level;
  power_down_pkg::wake_req_s wake_req, r;
  power_down_pkg::module_clk_en_s module_clk_en;
  logic [15:0] lfsr = 16'h859C;
  logic [7:0] shadow [4];
  logic [3:0] addrs [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
  logic [7:0] masks [4] = '{8'h88, 8'hC6, 8'h17, 8'h11};
  int errors = 0;
  int tests_run = 0;
  int n_exc = 0;
  int n_res = 0;
  int n_mode = 0;
  int b, k, i, nr;

  always #12.5 core_clk = ~core_clk;

  power_down_mode_controller dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
    .debug_reset(debug_reset), .core_mask_level(core_mask_level),
    .wake_req(wake_req), .watchdog_clock_divider(divider),
    .mode_pins(mode_pins), .core_halt(core_halt),
    .internal_clk_en(internal_clk_en), .periph_clk_en(periph_clk_en),
    .external_clock_output_en(ext_clk_en),
    .match_timer_init(match_timer_init), .take_exception(take_exception),
    .resume_after_halt(resume_after_halt), .mode_apply(mode_apply),
    .mode_applied(mode_applied),
    .watchdog_overflow_flag_set(watchdog_overflow_flag_set),
    .watchdog_counter(watchdog_counter), .module_clk_en(module_clk_en));

  core_irq_model model (.core_clk(core_clk), .take_exception(take_exception),
    .resume_after_halt(resume_after_halt), .halt_exec(halt_exec),
    .debug_reset(debug_reset), .core_mask_level(core_mask_level),
    .wake_req(wake_req), .watchdog_clock_divider(divider),
    .mode_pins(mode_pins));

  always @(posedge core_clk) begin
    if (take_exception === 1'b1) n_exc++;
    if (resume_after_halt === 1'b1) n_res++;
    if (mode_apply === 1'b1) n_mode++;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // a set stop bit turns the matching clock enable off
  function automatic logic [9:0] exp_en(input logic [7:0] a, bb, c);
    return {~a[7], ~a[6], ~a[2], ~a[1], ~bb[4], ~bb[2], ~bb[1], ~bb[0],
      ~c[4], ~c[0]};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wait_cnt(ref int c, input int base, input int lim);
    for (int j = 0; j < lim && c == base; j++) tick(1);
  endtask

  task automatic reg_case(input int idx, input logic [7:0] v);
    wr(addrs[idx], v);
    shadow[idx] = v & masks[idx];
    rd(addrs[idx], rv);
    chk("register readback", shadow[idx], rv);
    chk("clock enables", exp_en(shadow[1], shadow[2], shadow[3]),
      module_clk_en);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    $display("[ERR] watchdog expired before the sequence ended");
    report_and_stop();
  end

  initial begin
    // reset stands well past oscillator settling
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(1);
    chk("enables after reset", 10'h3FF, module_clk_en);
    for (k = 0; k < 4; k++) begin
      shadow[k] = 8'h00;
      rd(addrs[k], rv);
      chk("reset value", 8'h00, rv);
    end
    $display("test reset done");
    for (k = 0; k < 4; k++) reg_case(k, 8'hFF);
    for (k = 0; k < 4; k++) reg_case(k, 8'h00);
    wr(4'h2, 8'hFF);
    rd(4'h2, rv);
    chk("unmapped read", 8'h00, rv);
    for (i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      reg_case(int'(lfsr[1:0]), lfsr[15:8]);
    end
    reg_case(2, 8'h10);
    $display("test registers done");
    wr(4'h0, 8'h00);
    model.set_mask(4'h5);
    model.halt();
    tick(2);
    chk("sleep halt", 1, core_halt);
    chk("sleep clocks", 3'h7,
      {internal_clk_en, periph_clk_en, ext_clk_en});
    r = '0;
    r.user_break = 1'b1;
    r.ext_irq = 1'b1;
    r.ext_irq_sense = 2'h1;
    r.ext_irq_match = 1'b1;
    r.ext_irq_priority = 4'h5;
    r.periph_irq = 1'b1;
    r.periph_irq_priority = 4'h5;
    b = n_exc;
    model.raise(r);
    tick(6);
    chk("masked stays asleep", 1, core_halt);
    r.periph_irq_priority = 4'h6;
    model.raise(r);
    wait_cnt(n_exc, b, 10);
    chk("sleep wake exception", b + 1, n_exc);
    chk("awake", 0, core_halt);
    model.halt();
    tick(2);
    model.dbg_reset();
    tick(3);
    chk("debug reset wake", 0, core_halt);
    $display("test light sleep done");
    wr(4'h0, 8'h88);
    model.halt();
    tick(2);
    chk("standby clocks", 3'h0,
      {internal_clk_en, periph_clk_en, ext_clk_en});
    chk("timer init", 1, match_timer_init);
    r = '0;
    r.ext_irq = 1'b1;
    r.ext_irq_match = 1'b1;
    r.ext_irq_priority = 4'hF;
    model.raise(r);
    tick(10);
    chk("low level no wake", 0, internal_clk_en);
    r = '0;
    r.nmi = 1'b1;
    b = n_exc;
    k = n_mode;
    model.raise(r);
    tick(100);
    chk("clocks off settling", 0, internal_clk_en);
    wait_cnt(n_exc, b, 600);
    chk("nmi wake", b + 1, n_exc);
    chk("clocks back", 1, internal_clk_en);
    chk("mode applied", k + 1, n_mode);
    chk("mode value", 3'h5, mode_applied);
    chk("no overflow flag", 0, watchdog_overflow_flag_set);
    for (i = 0; i < 600 && internal_clk_en !== 1'b0; i++) tick(1);
    chk("relocked", 0, internal_clk_en);
    model.raise(r);
    tick(10);
    chk("locked ignores nmi", 0, internal_clk_en);
    model.raise('0);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    tick(2);
    chk("clock out in reset", 1, ext_clk_en);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(2);
    chk("reset exit", 10'h3FF, module_clk_en);
    chk("reset awake", 0, core_halt);
    $display("test deep standby done");
    model.set_mask(4'h5);
    for (i = 0; i < 2; i++) begin
      wr(4'h0, 8'h80);
      model.set_div(3'(i));
      model.halt();
      tick(2);
      r = '0;
      r.ext_irq = 1'b1;
      r.ext_irq_match = 1'b1;
      r.ext_irq_sense = 2'h1 + 2'(i);
      r.ext_irq_priority = (i == 0) ? 4'h3 : 4'h9;
      b = n_exc;
      nr = n_res;
      k = n_mode;
      model.raise(r);
      for (int j = 0; j < 1200 && n_res + n_exc == b + nr; j++) tick(1);
      chk("masked resume", 1 - i, n_res - nr);
      chk("exception taken", i, n_exc - b);
      chk("no mode apply", k, n_mode);
      wr(4'h0, 8'h00);
      tick(1);
      c1 = watchdog_counter;
      tick(300);
      chk("counter stopped", c1, watchdog_counter);
      chk("still running", 1, internal_clk_en);
    end
    $display("test interrupt wake done");
    report_and_stop();
  end
endmodule // test_power_down_mode_controller

`default_nettype wire
